/* design/vic_pkg.sv */
// Purpose: shared constants and types of the vectored interrupt controller
// Assumes: 32 sources, 32-bit register port with word addresses in bytes
// Notes:   all offsets are byte addresses on the register port
package vic_pkg;
  localparam int          NSRC        = 32;
  localparam int          AW          = 9;
  localparam int          DW          = 32;
  // register map
  localparam logic [8:0]  MODE_BASE   = 9'h000;
  localparam logic [8:0]  VEC_BASE    = 9'h080;
  localparam logic [8:0]  NORM_RB     = 9'h100;
  localparam logic [8:0]  FAST_RB     = 9'h104;
  localparam logic [8:0]  CUR_ID      = 9'h108;
  localparam logic [8:0]  PEND_ST     = 9'h10C;
  localparam logic [8:0]  MASK_ST     = 9'h110;
  localparam logic [8:0]  LINE_ST     = 9'h114;
  localparam logic [8:0]  EN_CMD      = 9'h120;
  localparam logic [8:0]  DIS_CMD     = 9'h124;
  localparam logic [8:0]  SPUR_VEC    = 9'h134;
  localparam logic [8:0]  EV_STATUS   = 9'h140;
  localparam logic [8:0]  EV_ENABLE   = 9'h144;
  localparam logic [8:0]  EV_CLEAR    = 9'h148;
  // mode word layout
  localparam int          PRIO_LSB    = 0;
  localparam int          TYPE_LSB    = 5;
  // line status bits
  localparam int          LINE_FAST   = 0;
  localparam int          LINE_NORM   = 1;
  // event bits
  localparam int          EV_NORM     = 0;
  localparam int          EV_FAST     = 1;
  localparam int          EV_SPUR     = 2;
  localparam int          EVW         = 3;
  // sources wired to pins: fast source and two externals
  localparam logic [31:0] EXT_MASK    = 32'hC000_0001;
  localparam logic [31:0] ZERO32      = 32'h0000_0000;
  localparam logic [2:0]  PRIO_MIN    = 3'h0;

  typedef struct packed {
    logic [31:0]          s1;      // first sync stage
    logic [31:0]          s2;      // second sync stage
    logic [31:0]          prev;    // last synced sample
    logic [31:0]          pend;
    logic [31:0]          mask;
    logic [31:0][2:0]     prio;
    logic [31:0][1:0]     ttype;
    logic [31:0][31:0]    vec;
    logic [31:0]          spur;
    logic                 cur_valid;
    logic [4:0]           cur_id;
    logic                 fast_n;
    logic                 norm_n;
    logic [EVW-1:0]       ev_st;
    logic [EVW-1:0]       ev_en;
    logic                 irq;
    logic [31:0]          rd_data;
  } vic_state_t;
endpackage

/* design/vic_top.sv */
// Purpose: vectored interrupt controller, software-visible core
// Assumes: sources arrive unsynchronised, single clock core_clk
// Notes:   request lines to the core are active low
`timescale 1ns/1ps
`default_nettype none
module vic_top (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst,
  // register port
  input  wire logic [8:0]        addr,
  input  wire logic [31:0]       wr_data,
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  output logic      [31:0]       rd_data,
  // interrupt sources from pins and peripherals
  input  wire logic [31:0]       src_in,
  // request lines to the core
  output logic                   fast_request_line_n,
  output logic                   normal_request_line_n,
  // controller event interrupt
  output logic                   irq
);
  vic_pkg::vic_state_t q;
  vic_pkg::vic_state_t d;

  // state update
  always_comb begin
    logic [31:0]  act_hi;
    logic [31:0]  edge_hit;
    logic [31:0]  sig;
    logic [31:0]  clr;
    logic [31:0]  cand;
    logic         best_v;
    logic [2:0]   best_p;
    logic [4:0]   best_i;
    logic         mode_hit;
    logic         vec_hit;
    logic [4:0]   idx;
    logic [vic_pkg::EVW-1:0] ev;
    logic [vic_pkg::EVW-1:0] ev_clr;
    act_hi   = vic_pkg::ZERO32;
    edge_hit = vic_pkg::ZERO32;
    sig      = vic_pkg::ZERO32;
    clr      = vic_pkg::ZERO32;
    cand     = vic_pkg::ZERO32;
    best_v   = 1'b0;
    best_p   = vic_pkg::PRIO_MIN;
    best_i   = 5'h00;
    ev       = '0;
    ev_clr   = '0;
    d        = q;
    idx      = addr[6:2];
    mode_hit = (addr[8:7] == vic_pkg::MODE_BASE[8:7]);
    vec_hit  = (addr[8:7] == vic_pkg::VEC_BASE[8:7]);

    // two-stage synchroniser on all sources
    d.s1   = src_in;
    d.s2   = q.s1;
    d.prev = q.s2;

    // edge-pending clears on vector readback
    if (rd_en && addr == vic_pkg::NORM_RB && q.cur_valid) begin
      clr[q.cur_id] = 1'b1;
    end
    if (rd_en && addr == vic_pkg::FAST_RB) begin
      clr[0] = 1'b1;
    end

    // trigger decode and pending per source
    for (int i = 0; i < vic_pkg::NSRC; i++) begin
      act_hi[i] = vic_pkg::EXT_MASK[i] ? q.ttype[i][1] : 1'b1;
      sig[i] = act_hi[i] ? q.s2[i] : ~q.s2[i];
      edge_hit[i] = act_hi[i] ? (q.s2[i] & ~q.prev[i]) : (~q.s2[i] & q.prev[i]);
      if (!q.ttype[i][0]) begin
        d.pend[i] = sig[i];
      end else begin
        d.pend[i] = edge_hit[i] | (q.pend[i] & ~clr[i]);
      end
    end

    // urgency arbitration over non-fast sources
    cand = q.pend & q.mask;
    for (int i = 1; i < vic_pkg::NSRC; i++) begin
      if (cand[i] && (!best_v || q.prio[i] > best_p)) begin
        best_v = 1'b1;
        best_p = q.prio[i];
        best_i = i[4:0];
      end
    end
    d.cur_valid = best_v;
    d.cur_id    = best_i;
    // source 0 never enters arbitration, its urgency is unused
    d.fast_n    = ~(cand[0]);
    d.norm_n    = ~best_v;

    // register writes
    if (wr_en) begin
      if (mode_hit) begin
        d.prio[idx]  = wr_data[vic_pkg::PRIO_LSB +: 3];
        d.ttype[idx] = wr_data[vic_pkg::TYPE_LSB +: 2];
      end
      if (vec_hit) begin
        d.vec[idx] = wr_data;
      end
      case (addr)
        vic_pkg::EN_CMD: begin
          d.mask = q.mask | wr_data;
        end
        vic_pkg::DIS_CMD: begin
          d.mask = q.mask & ~wr_data;
        end
        vic_pkg::SPUR_VEC: begin
          d.spur = wr_data;
        end
        vic_pkg::EV_ENABLE: begin
          d.ev_en = wr_data[vic_pkg::EVW-1:0];
        end
        vic_pkg::EV_CLEAR: begin
          ev_clr = wr_data[vic_pkg::EVW-1:0];
        end
        default: begin
          d.spur = q.spur;
        end
      endcase
    end

    // register reads, data valid next cycle
    d.rd_data = vic_pkg::ZERO32;
    if (rd_en) begin
      if (mode_hit) begin
        d.rd_data[vic_pkg::PRIO_LSB +: 3] = q.prio[idx];
        d.rd_data[vic_pkg::TYPE_LSB +: 2] = q.ttype[idx];
      end else if (vec_hit) begin
        d.rd_data = q.vec[idx];
      end else begin
        case (addr)
          vic_pkg::NORM_RB: begin
            d.rd_data = q.cur_valid ? q.vec[q.cur_id] : q.spur;
          end
          vic_pkg::FAST_RB: begin
            d.rd_data = !q.fast_n ? q.vec[0] : q.spur;
          end
          vic_pkg::CUR_ID: begin
            d.rd_data[4:0] = q.cur_id;
          end
          vic_pkg::PEND_ST: begin
            d.rd_data = q.pend;
          end
          vic_pkg::MASK_ST: begin
            d.rd_data = q.mask;
          end
          vic_pkg::LINE_ST: begin
            d.rd_data[vic_pkg::LINE_FAST] = ~q.fast_n;
            d.rd_data[vic_pkg::LINE_NORM] = ~q.norm_n;
          end
          vic_pkg::SPUR_VEC: begin
            d.rd_data = q.spur;
          end
          vic_pkg::EV_STATUS: begin
            d.rd_data[vic_pkg::EVW-1:0] = q.ev_st;
          end
          vic_pkg::EV_ENABLE: begin
            d.rd_data[vic_pkg::EVW-1:0] = q.ev_en;
          end
          default: begin
            d.rd_data = vic_pkg::ZERO32;
          end
        endcase
      end
    end

    // sticky events, a set beats a clear
    ev[vic_pkg::EV_NORM] = q.norm_n & ~d.norm_n;
    ev[vic_pkg::EV_FAST] = q.fast_n & ~d.fast_n;
    ev[vic_pkg::EV_SPUR] = rd_en && addr == vic_pkg::NORM_RB && !q.cur_valid;
    d.ev_st = (q.ev_st & ~ev_clr) | ev;
    d.irq   = |(d.ev_st & d.ev_en);
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q        <= '0;
      q.fast_n <= 1'b1;
      q.norm_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign rd_data               = q.rd_data;
  assign fast_request_line_n   = q.fast_n;
  assign normal_request_line_n = q.norm_n;
  assign irq                   = q.irq;
endmodule
`default_nettype wire

/* testbench/vic_core_model.sv */
// Purpose: processor core side of the request lines
// Assumes: lines active low, sampled on core_clk
// Notes:   gives active-high view of both lines
`timescale 1ns/1ps
`default_nettype none
module vic_core_model (
  // clock
  input  wire logic core_clk,
  // request lines
  input  wire logic fast_n,
  input  wire logic norm_n,
  // decoded requests
  output logic      fast_act,
  output logic      norm_act
);
  // core samples both lines each rising edge
  always_ff @(posedge core_clk) begin
    fast_act <= !fast_n;
    norm_act <= !norm_n;
  end
endmodule
`default_nettype wire

/* testbench/vic_sva.sv */
// Purpose: port checks of the controller
// Assumes: one clock, reset active high
// Notes:   mask and spurious value kept as shadows
`timescale 1ns/1ps
`default_nettype none
module vic_sva (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // register port
  input  wire logic [8:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [31:0] rd_data,
  // request lines
  input  wire logic        fast_request_line_n,
  input  wire logic        normal_request_line_n
);
  logic [31:0] msk;
  logic [31:0] spu;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // shadows follow command and spurious writes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      msk <= 32'h0;
      spu <= 32'h0;
    end else if (wr_en) begin
      if (addr == vic_pkg::EN_CMD) msk <= msk | wr_data;
      if (addr == vic_pkg::DIS_CMD) msk <= msk & ~wr_data;
      if (addr == vic_pkg::SPUR_VEC) spu <= wr_data;
    end
  end
  a_id_upper: assert property ($past(rd_en) && $past(addr) == vic_pkg::CUR_ID
    |-> rd_data[31:5] == 27'h0) else $error("id upper bits set");
  a_fast_bit: assert property ($past(rd_en) && $past(addr) == vic_pkg::LINE_ST
    |-> rd_data[0] == !$past(fast_request_line_n)) else $error("fast bit wrong");
  a_norm_bit: assert property ($past(rd_en) && $past(addr) == vic_pkg::LINE_ST
    |-> rd_data[1] == !$past(normal_request_line_n)) else $error("normal bit wrong");
  a_mask_read: assert property ($past(rd_en) && $past(addr) == vic_pkg::MASK_ST
    |-> rd_data == $past(msk)) else $error("mask status wrong");
  a_fast_off: assert property (!msk[0] && !$past(msk[0])
    |-> fast_request_line_n) else $error("fast line while masked");
  a_norm_off: assert property (msk[31:1] == 31'h0 && $past(msk[31:1]) == 31'h0
    |-> normal_request_line_n) else $error("normal line while masked");
  a_spur_norm: assert property ($past(rd_en) && $past(addr) == vic_pkg::NORM_RB
    && $past(normal_request_line_n) |-> rd_data == $past(spu)) else $error("normal spurious");
  a_spur_fast: assert property ($past(rd_en) && $past(addr) == vic_pkg::FAST_RB
    && $past(fast_request_line_n) |-> rd_data == $past(spu)) else $error("fast spurious");
endmodule
bind vic_top vic_sva u_sva (.core_clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
  .fast_request_line_n, .normal_request_line_n);
`default_nettype wire

/* testbench/test_vectored_interrupt_ctrl.sv */
// Purpose: register-level test of the controller
// Assumes: 40 MHz clock, reset held 8 cycles
// Notes:   sources settle within 6 edges
`timescale 1ns/1ps
`default_nettype none
module test_vectored_interrupt_ctrl;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr_en = 1'b0;
  logic        rd_en = 1'b0;
  logic [8:0]  addr = 9'h0;
  logic [31:0] wr_data = 32'h0;
  logic [31:0] src_in = 32'hC000_0001;
  logic [31:0] rd_data;
  logic        fast_n, norm_n, irq, fast_act, norm_act;
  int          n_mismatch = 0;
  int          n_tests = 0;
  logic [8:0]  ra [10] = '{9'h000, 9'h080, 9'h100, 9'h104, 9'h108, 9'h10C, 9'h110, 9'h114, 9'h134, 9'h1FC};
  // clock and units
  always #12.5 core_clk = ~core_clk;
  vic_top dut (.core_clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .src_in,
    .fast_request_line_n(fast_n), .normal_request_line_n(norm_n), .irq);
  vic_core_model core (.core_clk, .fast_n, .norm_n, .fast_act, .norm_act);
  // compare and count
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  // bus accesses
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge core_clk);
    rd_en <= 1'b0;
    @(negedge core_clk);
    chk($sformatf("reg %h", a), rd_data, e);
  endtask
  task automatic src(input logic [31:0] v);
    @(posedge core_clk);
    src_in <= v;
    repeat (6) @(posedge core_clk);
  endtask
  task automatic final_report;
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // watchdog
  initial begin
    #100us;
    n_mismatch++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    foreach (ra[i]) rd(ra[i], 32'h0);
    wr(9'h134, 32'h5A5A_0000);
    rd(9'h134, 32'h5A5A_0000);
    wr(9'h000, 32'hFFFF_FFFF);
    rd(9'h000, 32'h0000_0067);
    wr(9'h000, 32'h0000_0007);
    for (int i = 0; i < 32; i++) wr(9'h080 + 9'(4 * i), 32'h1000_0000 + i);
    for (int i = 0; i < 32; i++) rd(9'h080 + 9'(4 * i), 32'h1000_0000 + i);
    wr(9'h120, 32'hF000_1221);
    wr(9'h120, 32'h0);
    rd(9'h110, 32'hF000_1221);
    wr(9'h124, 32'h3000_0001);
    rd(9'h110, 32'hC000_1220);
    // urgency and current source
    wr(9'h014, 32'h43);
    wr(9'h024, 32'h43);
    wr(9'h030, 32'h46);
    src(32'hC000_0221);
    rd(9'h10C, 32'h0000_0220);
    rd(9'h108, 32'h5);
    rd(9'h100, 32'h1000_0005);
    rd(9'h114, 32'h2);
    chk("core", {30'h0, fast_act, norm_act}, 32'h1);
    src(32'hC000_1221);
    rd(9'h108, 32'hC);
    wr(9'h024, 32'h47);
    rd(9'h108, 32'h9);
    src(32'hC000_0001);
    rd(9'h114, 32'h0);
    rd(9'h100, 32'h5A5A_0000);
    // fast source and event interrupt
    wr(9'h144, 32'h2);
    wr(9'h120, 32'h1);
    src(32'hC000_0000);
    rd(9'h114, 32'h1);
    rd(9'h104, 32'h1000_0000);
    chk("irq", {31'h0, irq}, 32'h1);
    src(32'hC000_0001);
    rd(9'h140, 32'h7);
    wr(9'h148, 32'h7);
    rd(9'h100, 32'h5A5A_0000);
    rd(9'h140, 32'h4);
    chk("irq", {31'h0, irq}, 32'h0);
    // trigger types, external and internal
    wr(9'h07C, 32'h20);
    wr(9'h078, 32'h0);
    wr(9'h008, 32'h20);
    wr(9'h00C, 32'h0);
    src(32'h0000_000D);
    rd(9'h10C, 32'hC000_000C);
    src(32'h8000_0001);
    rd(9'h10C, 32'hC000_0004);
    final_report();
  end
endmodule
`default_nettype wire
